// [hdl/acc_bus_gate.sv]
// Column output-bus connection timing for the two switched-capacitor blocks of a column
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_bus_gate #(
  parameter int CNT_W = `ACC_PHASE_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic phase_two_pin,
  input wire logic sample_hold_disable,
  input wire logic [1:0] out_enable,
  input wire logic [1:0] sc_phase_option,
  output logic [1:0] bus_connect
);

  acc_pkg::acc_gate_state_t q;
  acc_pkg::acc_gate_state_t d;
  logic late_half;

  always_comb begin
    d = q;
    d.sync1_q = phase_two_pin;
    d.sync2_q = q.sync1_q;
    // Length of the last phase two sets where its second half begins
    late_half = q.sync2_q && (q.cnt_q >= (q.prev_len_q >> 1));
    if (q.sync2_q) begin
      if (q.cnt_q != {CNT_W{1'b1}}) begin
        d.cnt_q = q.cnt_q + 1'b1;
      end
    end else begin
      if (q.cnt_q != '0) begin
        d.prev_len_q = q.cnt_q;
      end
      d.cnt_q = '0;
    end
    for (int k = 0; k < 2; k++) begin
      if (!out_enable[k] || !q.sync2_q) begin
        // Bus floats through phase one
        d.conn_q[k] = 1'b0;
      end else if (sample_hold_disable) begin
        d.conn_q[k] = 1'b1;
      end else if (sc_phase_option[k]) begin
        d.conn_q[k] = 1'b1;
      end else begin
        d.conn_q[k] = late_half;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus_connect = q.conn_q;

endmodule

// [hdl/acc_config.sv]
// AHB-Lite register bank for analog clock sources, bus timing and continuous-time control 0
`timescale 1ns/1ps
`include "acc_consts.svh"

module acc_config (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [`ACC_NUM_SRC-1:0] dig_block_out,
  input wire logic [`ACC_NUM_COL-1:0] phase_two,
  output logic analog_sysclk_a,
  output logic analog_sysclk_b,
  output logic [`ACC_NUM_SC-1:0] sc_bus_connect,
  output logic [4*`ACC_NUM_CT-1:0] ct_feedback_weight,
  output logic [5*`ACC_NUM_CT-1:0] ct_input_weight,
  output logic [`ACC_NUM_CT-1:0] ct_tap_to_inverting,
  output logic [`ACC_NUM_CT-1:0] ct_tap_to_output,
  output logic [`ACC_NUM_CT-1:0] ct_top_to_amp_output,
  output logic [`ACC_NUM_CT-1:0] ct_top_to_supply,
  output logic [4*`ACC_NUM_CT-1:0] ct_bottom_select
);

  acc_pkg::acc_state_t q;
  acc_pkg::acc_state_t d;
  logic [`ACC_NUM_SC-1:0] bus_conn;
  logic [7:0] addr_idx;
  logic addr_in_range;
  logic addr_take;

  // Register read mux; unmapped indices read as zero
  function automatic logic [7:0] acc_read(
    input acc_pkg::acc_state_t s,
    input logic [7:0] idx,
    input logic [`ACC_NUM_SC-1:0] conn
  );
    logic [7:0] v;
    v = 8'h00;
    if (idx == `ACC_IDX_CLK_SEL) begin
      v = s.clk_sel_q;
    end
    if (idx == `ACC_IDX_BUS_STAT) begin
      v = conn;
    end
    if (idx == `ACC_IDX_CLK_STAT) begin
      v = {6'h00, s.sysclk_b_q, s.sysclk_a_q};
    end
    for (int i = 0; i < `ACC_NUM_CT; i++) begin
      for (int r = 0; r < `ACC_CT_REGS; r++) begin
        if (idx == 8'(`ACC_IDX_CT_BASE + i * `ACC_CT_STRIDE + r)) begin
          v = s.ct_cr_q[i][r];
        end
      end
    end
    for (int b = 0; b < `ACC_NUM_SC; b++) begin
      for (int r = 0; r < `ACC_SC_REGS; r++) begin
        if (idx == 8'(`ACC_IDX_SC_BASE + b * `ACC_SC_REGS + r)) begin
          v = s.sc_cr_q[b][r];
        end
      end
    end
    return v;
  endfunction

  assign addr_idx = haddr[`ACC_IDX_MSB:`ACC_IDX_LSB];
  assign addr_in_range = (haddr[31:`ACC_IDX_MSB+1] == '0) && (haddr[1:0] == 2'b00);
  assign addr_take = hsel && hready && htrans[1];

  always_comb begin
    d = q;
    d.hreadyout_q = 1'b1;

    // Data phase of a write: store the low byte
    if (q.wr_pend_q) begin
      if (q.wr_idx_q == `ACC_IDX_CLK_SEL) begin
        d.clk_sel_q = hwdata[7:0];
      end
      for (int i = 0; i < `ACC_NUM_CT; i++) begin
        for (int r = 0; r < `ACC_CT_REGS; r++) begin
          if (q.wr_idx_q == 8'(`ACC_IDX_CT_BASE + i * `ACC_CT_STRIDE + r)) begin
            d.ct_cr_q[i][r] = hwdata[7:0];
          end
        end
      end
      for (int b = 0; b < `ACC_NUM_SC; b++) begin
        for (int r = 0; r < `ACC_SC_REGS; r++) begin
          if (q.wr_idx_q == 8'(`ACC_IDX_SC_BASE + b * `ACC_SC_REGS + r)) begin
            d.sc_cr_q[b][r] = hwdata[7:0];
          end
        end
      end
    end

    // Address phase; a read sees a write finishing in this same cycle
    d.wr_pend_q = 1'b0;
    if (addr_take) begin
      if (hwrite) begin
        d.wr_pend_q = addr_in_range;
        d.wr_idx_q = addr_idx;
      end else if (addr_in_range) begin
        d.hrdata_q = {24'h000000, acc_read(d, addr_idx, bus_conn)};
      end else begin
        d.hrdata_q = 32'h00000000;
      end
    end

    // Analog system clock sources
    d.sysclk_b_q = dig_block_out[q.clk_sel_q[`ACC_SRC_B_MSB:`ACC_SRC_B_LSB]];
    d.sysclk_a_q = dig_block_out[q.clk_sel_q[`ACC_SRC_A_MSB:`ACC_SRC_A_LSB]];

    // Continuous-time control 0 decode
    for (int i = 0; i < `ACC_NUM_CT; i++) begin
      d.fb_weight_q[i] = `ACC_TAP_MAX - q.ct_cr_q[i][0][`ACC_TAP_MSB:`ACC_TAP_LSB];
      d.in_weight_q[i] = {1'b0, q.ct_cr_q[i][0][`ACC_TAP_MSB:`ACC_TAP_LSB]} + 5'h01;
      d.tap_inv_q[i] = q.ct_cr_q[i][0][`ACC_GAIN_BIT];
      d.tap_out_q[i] = !q.ct_cr_q[i][0][`ACC_GAIN_BIT];
      d.top_amp_q[i] = q.ct_cr_q[i][0][`ACC_TOP_BIT];
      d.top_sup_q[i] = !q.ct_cr_q[i][0][`ACC_TOP_BIT];
      case (q.ct_cr_q[i][0][`ACC_BOT_MSB:`ACC_BOT_LSB])
        2'h0: d.bot_sel_q[i] = 4'h1;
        2'h1: d.bot_sel_q[i] = 4'h2;
        2'h2: d.bot_sel_q[i] = 4'h4;
        2'h3: d.bot_sel_q[i] = 4'h8;
        default: d.bot_sel_q[i] = 4'h0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Each column gates its row-one and row-two switched-capacitor blocks
  for (genvar c = 0; c < `ACC_NUM_COL; c++) begin : g_col
    acc_bus_gate #(
      .CNT_W(`ACC_PHASE_CNT_W)
    ) u_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .phase_two_pin(phase_two[c]),
      .sample_hold_disable(q.clk_sel_q[`ACC_SAMPLE_HOLD_DISABLE_BIT]),
      .out_enable({q.sc_cr_q[c+`ACC_NUM_COL][`ACC_SC_OUTEN_REG][`ACC_SC_OUTEN_BIT],
                   q.sc_cr_q[c][`ACC_SC_OUTEN_REG][`ACC_SC_OUTEN_BIT]}),
      .sc_phase_option({q.sc_cr_q[c+`ACC_NUM_COL][`ACC_SC_PHASE_REG][`ACC_SC_PHASE_BIT],
                        q.sc_cr_q[c][`ACC_SC_PHASE_REG][`ACC_SC_PHASE_BIT]}),
      .bus_connect({bus_conn[c+`ACC_NUM_COL], bus_conn[c]})
    );
  end

  assign hreadyout = q.hreadyout_q;
  assign hresp = 1'b0;
  assign hrdata = q.hrdata_q;
  assign analog_sysclk_a = q.sysclk_a_q;
  assign analog_sysclk_b = q.sysclk_b_q;
  assign sc_bus_connect = bus_conn;
  assign ct_feedback_weight = q.fb_weight_q;
  assign ct_input_weight = q.in_weight_q;
  assign ct_tap_to_inverting = q.tap_inv_q;
  assign ct_tap_to_output = q.tap_out_q;
  assign ct_top_to_amp_output = q.top_amp_q;
  assign ct_top_to_supply = q.top_sup_q;
  assign ct_bottom_select = q.bot_sel_q;

endmodule

// [hdl/acc_consts.svh]
// Constants for the analog clock and continuous-time configuration bank
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

`define ACC_NUM_CT 4
`define ACC_NUM_SC 8
`define ACC_NUM_COL 4
`define ACC_CT_REGS 3
`define ACC_SC_REGS 4
`define ACC_NUM_SRC 8

// Register indices; byte address is four times the index
`define ACC_IDX_CLK_SEL 8'h61
`define ACC_IDX_CT_BASE 8'h71
`define ACC_CT_STRIDE 4
`define ACC_IDX_SC_BASE 8'h80
`define ACC_IDX_BUS_STAT 8'h20
`define ACC_IDX_CLK_STAT 8'h21
`define ACC_IDX_MSB 9
`define ACC_IDX_LSB 2

`define ACC_REG_RESET 8'h00

// Clock select fields
`define ACC_SAMPLE_HOLD_DISABLE_BIT 6
`define ACC_SRC_B_MSB 5
`define ACC_SRC_B_LSB 3
`define ACC_SRC_A_MSB 2
`define ACC_SRC_A_LSB 0

// Continuous-time control 0 fields
`define ACC_TAP_MSB 7
`define ACC_TAP_LSB 4
`define ACC_GAIN_BIT 3
`define ACC_TOP_BIT 2
`define ACC_BOT_MSB 1
`define ACC_BOT_LSB 0
`define ACC_TAP_MAX 4'hF

// Switched-capacitor fields
`define ACC_SC_PHASE_REG 0
`define ACC_SC_PHASE_BIT 7
`define ACC_SC_OUTEN_REG 2
`define ACC_SC_OUTEN_BIT 7

`define ACC_PHASE_CNT_W 8

`endif

// [hdl/acc_pkg.sv]
// Types for the analog clock and continuous-time configuration bank
`include "acc_consts.svh"

package acc_pkg;

  typedef struct packed {
    logic [7:0] clk_sel_q;
    logic [`ACC_NUM_CT-1:0][`ACC_CT_REGS-1:0][7:0] ct_cr_q;
    logic [`ACC_NUM_SC-1:0][`ACC_SC_REGS-1:0][7:0] sc_cr_q;
    logic wr_pend_q;
    logic [7:0] wr_idx_q;
    logic [31:0] hrdata_q;
    logic hreadyout_q;
    logic sysclk_a_q;
    logic sysclk_b_q;
    logic [`ACC_NUM_CT-1:0][3:0] fb_weight_q;
    logic [`ACC_NUM_CT-1:0][4:0] in_weight_q;
    logic [`ACC_NUM_CT-1:0] tap_inv_q;
    logic [`ACC_NUM_CT-1:0] tap_out_q;
    logic [`ACC_NUM_CT-1:0] top_amp_q;
    logic [`ACC_NUM_CT-1:0] top_sup_q;
    logic [`ACC_NUM_CT-1:0][3:0] bot_sel_q;
  } acc_state_t;

  typedef struct packed {
    logic sync1_q;
    logic sync2_q;
    logic [`ACC_PHASE_CNT_W-1:0] cnt_q;
    logic [`ACC_PHASE_CNT_W-1:0] prev_len_q;
    logic [1:0] conn_q;
  } acc_gate_state_t;

endpackage

// [tb/acc_config_properties.sv]
// Port checker for the analog clock and continuous-time configuration bank
`timescale 1ns/1ps
module acc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0] dig_block_out,
  input wire logic [3:0] phase_two,
  input wire logic analog_sysclk_a,
  input wire logic analog_sysclk_b,
  input wire logic [7:0] sc_bus_connect,
  input wire logic [15:0] ct_feedback_weight,
  input wire logic [19:0] ct_input_weight,
  input wire logic [3:0] ct_tap_to_inverting,
  input wire logic [3:0] ct_tap_to_output,
  input wire logic [3:0] ct_top_to_amp_output,
  input wire logic [3:0] ct_top_to_supply,
  input wire logic [15:0] ct_bottom_select
);
  logic pend_q;
  logic [7:0] sel_q;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadow of the clock select register, rebuilt from bus writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_q <= 1'b0;
      sel_q <= 8'h00;
    end else begin
      pend_q <= hsel && hreadyout && htrans[1] && hwrite && haddr == 32'h00000184;
      if (pend_q) begin
        sel_q <= hwdata[7:0];
      end
    end
  end
  resp_okay_a: assert property (hresp == 1'b0) else $error("Response not OKAY");
  ready_up_a: assert property ($past(hresetn) |-> hreadyout) else $error("Wait state inserted");
  upper_zero_a: assert property (hrdata[31:8] == 24'h000000) else $error("Upper read bits set");
  clk_a_route_a: assert property ($past(hresetn) |-> analog_sysclk_a == $past(dig_block_out[sel_q[2:0]]))
    else $error("First analog clock source wrong");
  clk_b_route_a: assert property ($past(hresetn) |-> analog_sysclk_b == $past(dig_block_out[sel_q[5:3]]))
    else $error("Second analog clock source wrong");
  tap_weights_a: assert property ($past(hresetn) |-> ({1'b0, ct_feedback_weight[3:0]} + ct_input_weight[4:0]) == 5'h10)
    else $error("Tap weights do not sum to sixteen");
  gain_split_a: assert property ($past(hresetn) |-> (ct_tap_to_inverting ^ ct_tap_to_output) == 4'hF)
    else $error("Tap routing not exclusive");
  top_split_a: assert property ($past(hresetn) |-> (ct_top_to_amp_output ^ ct_top_to_supply) == 4'hF)
    else $error("Top routing not exclusive");
  bottom_onehot_a: assert property ($past(hresetn) |-> $onehot(ct_bottom_select[3:0]) && $onehot(ct_bottom_select[15:12]))
    else $error("Bottom select not one-hot");
  bus_float_a: assert property ((phase_two == 4'h0) [*4] |=> sc_bus_connect == 8'h00)
    else $error("Bus connected outside phase two");
endmodule
bind acc_config acc_checker acc_checker_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hreadyout,
  .hresp, .hrdata, .dig_block_out, .phase_two, .analog_sysclk_a, .analog_sysclk_b, .sc_bus_connect,
  .ct_feedback_weight, .ct_input_weight, .ct_tap_to_inverting, .ct_tap_to_output, .ct_top_to_amp_output,
  .ct_top_to_supply, .ct_bottom_select);

// [tb/testbench.sv]
// Self-checking bench for the configuration bank over AHB-Lite
`timescale 1ns/1ps
module testbench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] dig = 8'h00;
  logic [3:0] ph = 4'h0;
  logic hreadyout, hresp, sa, sb;
  logic [31:0] hrdata, rd;
  logic [7:0] conn, d;
  logic [15:0] fb, bot;
  logic [19:0] inw;
  logic [3:0] inv, outp, amp, sup;
  int i;
  int err_total = 0;
  int n_compared = 0;
  always #25 hclk = ~hclk;
  acc_config acc_config_i (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dig_block_out(dig), .phase_two(ph), .analog_sysclk_a(sa), .analog_sysclk_b(sb),
    .sc_bus_connect(conn), .ct_feedback_weight(fb), .ct_input_weight(inw), .ct_tap_to_inverting(inv),
    .ct_tap_to_output(outp), .ct_top_to_amp_output(amp), .ct_top_to_supply(sup), .ct_bottom_select(bot));
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] v);
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= {24'h000000, v};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task rdchk(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask
  // One phase-two pulse on column 0; looks at the connection three edges in and near the end
  task phase(input int len, input logic [7:0] e3, input logic [7:0] e_end);
    @(posedge hclk);
    ph <= 4'h1;
    repeat (3) @(posedge hclk);
    #1 chk(conn, e3);
    repeat (len - 3) @(posedge hclk);
    #1 chk(conn, e_end);
    @(posedge hclk);
    ph <= 4'h0;
    repeat (len) @(posedge hclk);
  endtask
  task test_done;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #200us;
    err_total++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1 chk({fb, bot}, 32'hFFFF1111);
    chk({inw, inv, outp, amp, sup}, 36'h084210F0F);
    rdchk(32'h184, 32'h0);
    rdchk(32'h1C4, 32'h0);
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, 32'h184, {2'b00, 3'(7 - k), 3'(k)});
      dig <= 8'h01 << k;
      repeat (2) @(posedge hclk);
      #1 chk({sb, sa}, 32'h1);
      rdchk(32'h184, {24'h0, 2'b00, 3'(7 - k), 3'(k)});
    end
    rdchk(32'h84, 32'h1);
    for (int n = 0; n < 16; n++) begin
      i = n % 4;
      d = {4'(n), ~n[0], n[1], n[2:1]};
      xfer(1'b1, 32'h1C4 + 16 * i, d);
      @(posedge hclk);
      #1 chk({fb[4*i+:4], inw[5*i+:5]}, {4'(15 - d[7:4]), 5'(d[7:4] + 1)});
      chk({inv[i], outp[i]}, {d[3], !d[3]});
      chk({amp[i], sup[i]}, {d[2], !d[2]});
      chk(bot[4*i+:4], 4'h1 << d[1:0]);
      rdchk(32'h1C4 + 16 * i, d);
    end
    xfer(1'b1, 32'h400, 8'hFF);
    rdchk(32'h400, 32'h0);
    rdchk(32'h184, 32'h07);
    xfer(1'b1, 32'h208, 8'h80);
    xfer(1'b1, 32'h184, 8'h40);
    phase(10, 8'h01, 8'h01);
    xfer(1'b1, 32'h184, 8'h00);
    phase(10, 8'h00, 8'h01);
    xfer(1'b1, 32'h200, 8'h80);
    phase(10, 8'h01, 8'h01);
    rdchk(32'h80, 32'h0);
    // Last length now known, so only the disable bit can connect early; row two joins
    xfer(1'b1, 32'h200, 8'h00);
    xfer(1'b1, 32'h248, 8'h80);
    xfer(1'b1, 32'h184, 8'h40);
    phase(10, 8'h11, 8'h11);
    test_done;
  end
endmodule
